// ### hdl/fifo_host.sv
// host controller driving an asynchronous 9-bit fifo over its pins
`timescale 1ns/100ps
module fifo_host #(
  parameter int DEPTH = fifo_host_pkg::DEPTH_DEF,
  parameter int WIDTH = fifo_host_pkg::WORD_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic store_n,
  output logic fetch_n,
  output logic clear_n,
  output logic replay_n,
  output logic [WIDTH-1:0] input_bus,
  input wire logic [WIDTH-1:0] output_bus,
  input wire logic vacant_flag_n,
  input wire logic halfway_flag_n,
  input wire logic capacity_flag_n,
  output logic chain_input_n,
  output logic lead_device_sel_n
);
  // shallow depths stay legal so short benches can reach full
  if (WIDTH % 9 != 0 || WIDTH > 27 || DEPTH < 2 || DEPTH > 4096) begin : g_bad_cfg
    $error("fifo_host: unsupported width or depth");
  end
  // ------------------------------------------------------------
  // flag inputs synchronised
  // ------------------------------------------------------------
  logic [2:0] flags_q;
  pin_sync #(.W(3)) u_flag_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin_in({capacity_flag_n, halfway_flag_n, vacant_flag_n}),
    .rst_val(3'h6),
    .stable_q(flags_q)
  );
  wire vacant_n = flags_q[0];
  wire halfway_n = flags_q[1];
  wire capacity_n = flags_q[2];
  // ------------------------------------------------------------
  // sequencer state
  // ------------------------------------------------------------
  fifo_host_pkg::phase_t phase_q, phase_d;
  fifo_host_pkg::op_t op_q;
  logic [3:0] cnt_q;
  logic [WIDTH-1:0] wdata_q;
  logic [WIDTH-1:0] rdata_q;
  logic wr_pend_q, rd_pend_q, clr_pend_q, rep_pend_q;
  logic rd_valid_q, drop_q;
  logic [31:0] rdata_bus_q;
  logic [12:0] level_q;
  logic [12:0] since_clr_q;
  wire idle = (phase_q == fifo_host_pkg::ST_IDLE);
  wire cnt_done = (cnt_q == 4'h0);
  wire wr_reg = reg_wr && reg_addr == fifo_host_pkg::REG_WDATA;
  wire ctrl_reg = reg_wr && reg_addr == fifo_host_pkg::REG_CTRL;
  // strap outputs: standalone configuration
  // chain grounded, lead strap high
  assign chain_input_n = 1'b0;
  assign lead_device_sel_n = 1'b1;
  // no write while capacity flag low
  wire wr_ok = wr_pend_q && capacity_n;
  // fetch only once vacant flag high
  wire rd_ok = rd_pend_q && vacant_n;
  function automatic logic [3:0] cyc(input int n);
    cyc = 4'((n < 1) ? 0 : n - 1);
  endfunction
  // ------------------------------------------------------------
  // phase transitions
  // ------------------------------------------------------------
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      fifo_host_pkg::ST_IDLE: begin
        if (clr_pend_q || rep_pend_q || wr_ok || rd_ok) begin
          phase_d = fifo_host_pkg::ST_ACT;
        end
      end
      fifo_host_pkg::ST_ACT: begin
        if (cnt_done) begin
          phase_d = fifo_host_pkg::ST_REC;
        end
      end
      fifo_host_pkg::ST_REC: begin
        if (cnt_done) begin
          phase_d = fifo_host_pkg::ST_SETTLE;
        end
      end
      fifo_host_pkg::ST_SETTLE: begin
        if (cnt_done) begin
          phase_d = fifo_host_pkg::ST_IDLE;
        end
      end
      default: phase_d = fifo_host_pkg::ST_IDLE;
    endcase
  end
  // ------------------------------------------------------------
  // strobe drive
  // ------------------------------------------------------------
  wire act = (phase_q == fifo_host_pkg::ST_ACT);
  // clear only with both strobes high
  // replay only with both strobes high
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      store_n <= 1'b1;
      fetch_n <= 1'b1;
      clear_n <= 1'b1;
      replay_n <= 1'b1;
    end else begin
      // store low pulse, data held past rise
      store_n <= !(phase_d == fifo_host_pkg::ST_ACT && (act ? op_q == fifo_host_pkg::OP_WRITE
                 : (!clr_pend_q && !rep_pend_q && wr_ok)));
      fetch_n <= !(phase_d == fifo_host_pkg::ST_ACT && (act ? op_q == fifo_host_pkg::OP_READ
                 : (!clr_pend_q && !rep_pend_q && !wr_ok && rd_ok)));
      clear_n <= !(phase_d == fifo_host_pkg::ST_ACT && (act ? op_q == fifo_host_pkg::OP_CLEAR : clr_pend_q));
      replay_n <= !(phase_d == fifo_host_pkg::ST_ACT && (act ? op_q == fifo_host_pkg::OP_REPLAY
                  : (!clr_pend_q && rep_pend_q)));
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      phase_q <= fifo_host_pkg::ST_IDLE;
      op_q <= fifo_host_pkg::OP_WRITE;
      cnt_q <= 4'h0;
    end else begin
      phase_q <= phase_d;
      if (idle && phase_d == fifo_host_pkg::ST_ACT) begin
        cnt_q <= cyc(fifo_host_pkg::PULSE_CYC);
        op_q <= clr_pend_q ? fifo_host_pkg::OP_CLEAR : rep_pend_q ? fifo_host_pkg::OP_REPLAY
              : wr_ok ? fifo_host_pkg::OP_WRITE : fifo_host_pkg::OP_READ;
      end else if (phase_d != phase_q) begin
        cnt_q <= (phase_d == fifo_host_pkg::ST_REC) ? cyc(fifo_host_pkg::RECOVERY_CYC)
               : cyc(fifo_host_pkg::FLAG_CYC + 3);
      end else if (!cnt_done) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
  // ------------------------------------------------------------
  // requests and captured data
  // ------------------------------------------------------------
  wire start = idle && phase_d == fifo_host_pkg::ST_ACT;
  wire go_wr = start && !clr_pend_q && !rep_pend_q && wr_ok;
  wire go_rd = start && !clr_pend_q && !rep_pend_q && !wr_ok && rd_ok;
  // replay only meaningful while no word has been overwritten
  wire replay_ok = since_clr_q <= 13'(DEPTH);
  // sample output bus late in the fetch pulse, just before rise
  wire rd_sample = act && op_q == fifo_host_pkg::OP_READ && cnt_done;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      clr_pend_q <= 1'b1;
      rep_pend_q <= 1'b0;
      rd_valid_q <= 1'b0;
      drop_q <= 1'b0;
      wdata_q <= '0;
      rdata_q <= '0;
      input_bus <= '0;
      level_q <= 13'h0000;
      since_clr_q <= 13'h0000;
    end else begin
      // a new request wins over completion in the same cycle
      wr_pend_q <= wr_reg || (wr_pend_q && !go_wr);
      // a word launched in the same cycle is not lost
      if (wr_reg && wr_pend_q && !go_wr) begin
        drop_q <= 1'b1;
      end else if (ctrl_reg && reg_wdata[fifo_host_pkg::CTRL_DROP]) begin
        drop_q <= 1'b0;
      end
      if (wr_reg) begin
        wdata_q <= reg_wdata[WIDTH-1:0];
      end
      if (go_wr) begin
        input_bus <= wdata_q;
      end
      rd_pend_q <= (ctrl_reg && reg_wdata[fifo_host_pkg::CTRL_READ]) || (rd_pend_q && !go_rd);
      clr_pend_q <= (ctrl_reg && reg_wdata[fifo_host_pkg::CTRL_CLEAR])
                    || (clr_pend_q && !(start && clr_pend_q));
      // replay refused past depth since clear
      rep_pend_q <= (ctrl_reg && reg_wdata[fifo_host_pkg::CTRL_REPLAY] && replay_ok)
                    || (rep_pend_q && !(start && !clr_pend_q && rep_pend_q));
      // data captured in the fetch pulse, valid flag held until rdata is read
      if (rd_sample) begin
        rdata_q <= output_bus;
        rd_valid_q <= 1'b1;
      end else if (reg_rd && reg_addr == fifo_host_pkg::REG_RDATA && !rd_sample) begin
        rd_valid_q <= 1'b0;
      end
      if (start && clr_pend_q) begin
        level_q <= 13'h0000;
      end else if (start && rep_pend_q) begin
        level_q <= since_clr_q;
      end else if (go_wr && !go_rd) begin
        level_q <= level_q + 13'h0001;
      end else if (go_rd && level_q != 13'h0000) begin
        level_q <= level_q - 13'h0001;
      end
      // writes since clear, saturating just past depth
      if (start && clr_pend_q) begin
        since_clr_q <= 13'h0000;
      end else if (go_wr && replay_ok) begin
        since_clr_q <= since_clr_q + 13'h0001;
      end
    end
  end
  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  // composite flags left to chain logic; status shows device flags
  wire [31:0] status_word = {24'h00_0000, drop_q, rd_valid_q, rd_pend_q, wr_pend_q, !idle,
                             !capacity_n, !halfway_n, !vacant_n};
  wire [31:0] rd_mux = (reg_addr == fifo_host_pkg::REG_STATUS) ? status_word
                     : (reg_addr == fifo_host_pkg::REG_RDATA) ? 32'(rdata_q)
                     : (reg_addr == fifo_host_pkg::REG_WDATA) ? 32'(wdata_q)
                     : (reg_addr == fifo_host_pkg::REG_COUNT) ? 32'(level_q)
                     : 32'h0000_0000;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdata_bus_q <= 32'h0000_0000;
    end else begin
      rdata_bus_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_bus_q;
endmodule

// ### hdl/fifo_host_pkg.sv
// constants shared by the fifo host controller
package fifo_host_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int PULSE_NS = 65;
  localparam int RECOVERY_NS = 15;
  localparam int FLAG_NS = 60;
  localparam int PULSE_CYC = (PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECOVERY_CYC = (RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FLAG_CYC = (FLAG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WORD_W = 9;
  localparam int DEPTH_DEF = 256;
  // ------------------------------------------------------------
  // register offsets of the controller
  // ------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_WDATA = 4'h1;
  localparam logic [3:0] REG_RDATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_COUNT = 4'h4;
  localparam int CTRL_CLEAR = 0;
  localparam int CTRL_REPLAY = 1;
  localparam int CTRL_READ = 2;
  localparam int CTRL_DROP = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACT = 3'b001,
    ST_REC = 3'b011,
    ST_SETTLE = 3'b010
  } phase_t;
  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ = 2'b01,
    OP_CLEAR = 2'b11,
    OP_REPLAY = 2'b10
  } op_t;
endpackage

// ### hdl/pin_sync.sv
// three-stage synchroniser for pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] stable_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  wire [W-1:0] agree = ~(s2_q ^ s3_q);
  // ------------------------------------------------------------
  // stages
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    s1_q <= pin_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  // change counts only when second and third agree
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stable_q <= rst_val;
    end else begin
      stable_q <= (agree & s3_q) | (~agree & stable_q);
    end
  end
endmodule

// ### tb/fifo_host_properties.sv
// pin-level assertions for the fifo host
`timescale 1ns/100ps
module fifo_host_properties #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 9
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic store_n,
  input wire logic fetch_n,
  input wire logic clear_n,
  input wire logic replay_n,
  input wire logic [WIDTH-1:0] input_bus,
  input wire logic capacity_flag_n,
  input wire logic vacant_flag_n,
  input wire logic chain_input_n,
  input wire logic lead_device_sel_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  wire quiet = store_n && fetch_n;
  sequence low3(s);
    !s ##1 !s ##1 !s ##1 s;
  endsequence
  store_pulse_a: assert property ($fell(store_n) |-> low3(store_n)) else $error("store pulse width");
  fetch_pulse_a: assert property ($fell(fetch_n) |-> low3(fetch_n)) else $error("fetch pulse width");
  clear_pulse_a: assert property ($fell(clear_n) |-> low3(clear_n)) else $error("clear pulse width");
  replay_pulse_a: assert property ($fell(replay_n) |-> low3(replay_n)) else $error("replay pulse width");
  strobes_quiet_a: assert property (!clear_n || !replay_n |-> quiet) else $error("strobe during clear");
  recovery_quiet_a: assert property ($rose(clear_n) || $rose(replay_n) |-> quiet ##1 quiet) else $error("recovery");
  data_hold_a: assert property (!store_n && !$fell(store_n) |-> $stable(input_bus)) else $error("data moved");
  full_block_a: assert property ((!capacity_flag_n) [*6] |=> !$fell(store_n)) else $error("store when full");
  empty_block_a: assert property ((!vacant_flag_n) [*6] |=> !$fell(fetch_n)) else $error("fetch when empty");
  clear_first_a: assert property ($rose(reset_n) |-> quiet throughout (##[0:10] !clear_n)) else $error("no clear");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("stray read data");
  strap_level_a: assert property (!chain_input_n && lead_device_sel_n) else $error("standalone straps");
endmodule
bind fifo_host fifo_host_properties #(.DEPTH(DEPTH), .WIDTH(WIDTH)) chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .store_n(store_n), .fetch_n(fetch_n), .clear_n(clear_n),
  .replay_n(replay_n), .input_bus(input_bus), .capacity_flag_n(capacity_flag_n), .vacant_flag_n(vacant_flag_n),
  .chain_input_n(chain_input_n), .lead_device_sel_n(lead_device_sel_n));

// ### tb/fifo_model.sv
// behavioural model of the asynchronous nine-bit fifo
`timescale 1ns/100ps
module fifo_model #(
  parameter int DEPTH = 8
) (
  input wire logic store_n,
  input wire logic fetch_n,
  input wire logic clear_n,
  input wire logic replay_n,
  input wire logic [8:0] input_bus,
  output logic [8:0] output_bus,
  output logic vacant_flag_n,
  output logic halfway_flag_n,
  output logic capacity_flag_n
);
  logic [8:0] mem [DEPTH];
  int wp = 0;
  int rp = 0;
  int cnt = 0;
  logic drive = 1'b0;
  logic ready = 1'b0;
  logic [8:0] last = 9'h000;
  assign vacant_flag_n = cnt != 0;
  assign halfway_flag_n = !(cnt > DEPTH / 2);
  assign capacity_flag_n = cnt != DEPTH;
  // released bus shows inverse of last word
  assign output_bus = drive ? mem[rp] : ~last;
  always @(negedge clear_n) begin
    wp = 0;
    rp = 0;
    cnt = 0;
    ready = 1'b1;
  end
  always @(negedge replay_n) begin
    rp = 0;
    cnt = wp;
  end
  // stored at rising strobe, refused when full
  always @(posedge store_n) begin
    if (ready && cnt < DEPTH) begin
      mem[wp] = input_bus;
      wp = (wp + 1) % DEPTH;
      cnt++;
    end
  end
  always @(negedge fetch_n) drive = cnt != 0;
  always @(posedge fetch_n) begin
    if (drive) begin
      last = mem[rp];
      drive = 1'b0;
      rp = (rp + 1) % DEPTH;
      cnt--;
    end
  end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the fifo host controller
`timescale 1ns/100ps
module tb_top;
  localparam int DEPTH = 8;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, last;
  logic store_n, fetch_n, clear_n, replay_n, vf_n, hf_n, cf_n, chain_in_n, lead_n;
  logic [8:0] input_bus, output_bus;
  logic [8:0] words[$];
  logic [8:0] saved[$];
  note_t notes[$];
  note_t n;
  logic rd_seen = 1'b0;
  logic [31:0] seed = 32'h5c5e_2f7b;
  int n_errors = 0;
  int samples_checked = 0;
  fifo_host #(.DEPTH(DEPTH)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .store_n(store_n), .fetch_n(fetch_n), .clear_n(clear_n),
    .replay_n(replay_n), .input_bus(input_bus), .output_bus(output_bus), .vacant_flag_n(vf_n), .halfway_flag_n(hf_n),
    .capacity_flag_n(cf_n), .chain_input_n(chain_in_n), .lead_device_sel_n(lead_n));
  fifo_model #(.DEPTH(DEPTH)) fifo (.store_n(store_n), .fetch_n(fetch_n), .clear_n(clear_n), .replay_n(replay_n),
    .input_bus(input_bus), .output_bus(output_bus), .vacant_flag_n(vf_n), .halfway_flag_n(hf_n), .capacity_flag_n(cf_n));
  initial forever #12.5 clk_sys = ~clk_sys;
  // ------------------------------------------------------------
  // bus tasks and result watcher
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // mask zero marks a poll, kept out of the counts
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    notes.push_back('{e, m});
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    #1;
  endtask
  task automatic waitfor(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 80; i++) begin
      rd(fifo_host_pkg::REG_STATUS, 32'h0000_0000, 32'h0000_0000);
      if ((last & m) === v) return;
    end
    n_errors++;
    print_verdict();
  endtask
  task automatic put(input logic [8:0] w);
    wr(fifo_host_pkg::REG_WDATA, {23'h00_0000, w});
    words.push_back(w);
    waitfor(32'h0000_0038, 32'h0000_0000);
  endtask
  task automatic get();
    wr(fifo_host_pkg::REG_CTRL, 32'h0000_0004);
    waitfor(32'h0000_0078, 32'h0000_0040);
    rd(fifo_host_pkg::REG_RDATA, {23'h00_0000, words.pop_front()}, 32'h0000_01ff);
  endtask
  task automatic status(input logic [31:0] e, input logic [31:0] m);
    rd(fifo_host_pkg::REG_STATUS, e, m);
  endtask
  always @(posedge clk_sys) rd_seen <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_seen) begin
      last = reg_rdata;
      n = notes.pop_front();
      if (n.m != 0) begin
        samples_checked++;
        if ((reg_rdata & n.m) !== n.e) begin
          n_errors++;
          $display("MISMATCH t=%0t got %h exp %h", $time, reg_rdata & n.m, n.e);
        end
      end
    end
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    waitfor(32'h0000_0038, 32'h0000_0000);
    status(32'h0000_0001, 32'h0000_0007);
    wr(fifo_host_pkg::REG_CTRL, 32'h0000_0004);
    repeat (20) @(posedge clk_sys);
    status(32'h0000_0021, 32'h0000_0061);
    seed = xs(seed);
    wr(fifo_host_pkg::REG_WDATA, {23'h00_0000, seed[8:0]});
    words.push_back(seed[8:0]);
    waitfor(32'h0000_0078, 32'h0000_0040);
    rd(fifo_host_pkg::REG_RDATA, {23'h00_0000, words.pop_front()}, 32'h0000_01ff);
    status(32'h0000_0001, 32'h0000_0007);
    $display("test empty read done");
    for (int i = 1; i <= DEPTH; i++) begin
      seed = xs(seed);
      put(seed[8:0]);
      status({29'h0000_0000, i == DEPTH, i > DEPTH / 2, 1'b0}, 32'h0000_0007);
      rd(fifo_host_pkg::REG_COUNT, i, 32'h0000_1fff);
    end
    seed = xs(seed);
    wr(fifo_host_pkg::REG_WDATA, {23'h00_0000, seed[8:0]});
    words.push_back(seed[8:0]);
    repeat (20) @(posedge clk_sys);
    status(32'h0000_0014, 32'h0000_0014);
    seed = xs(seed);
    wr(fifo_host_pkg::REG_WDATA, {23'h00_0000, seed[8:0]});
    void'(words.pop_back());
    words.push_back(seed[8:0]);
    rd(fifo_host_pkg::REG_WDATA, {23'h00_0000, seed[8:0]}, 32'h0000_01ff);
    status(32'h0000_0094, 32'h0000_0094);
    get();
    waitfor(32'h0000_0038, 32'h0000_0000);
    status(32'h0000_0006, 32'h0000_0007);
    wr(fifo_host_pkg::REG_CTRL, 32'h0000_0008);
    status(32'h0000_0000, 32'h0000_0080);
    $display("test fill done");
    for (int i = DEPTH - 1; i >= 0; i--) begin
      get();
      status({29'h0000_0000, 1'b0, i > DEPTH / 2, i == 0}, 32'h0000_0007);
    end
    $display("test drain done");
    wr(fifo_host_pkg::REG_CTRL, 32'h0000_0002);
    waitfor(32'h0000_0038, 32'h0000_0000);
    status(32'h0000_0001, 32'h0000_0007);
    wr(fifo_host_pkg::REG_CTRL, 32'h0000_0001);
    waitfor(32'h0000_0038, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      put(seed[8:0]);
    end
    saved = words;
    for (int i = 0; i < 3; i++) get();
    wr(fifo_host_pkg::REG_CTRL, 32'h0000_0002);
    waitfor(32'h0000_0038, 32'h0000_0000);
    status(32'h0000_0000, 32'h0000_0007);
    rd(fifo_host_pkg::REG_COUNT, 32'h0000_0003, 32'h0000_1fff);
    words = saved;
    for (int i = 0; i < 3; i++) get();
    $display("test replay done");
    print_verdict();
  end
endmodule
